// [include/dsw_pkg.sv]
// Package of constants for the serial write port of the converter
package dsw_pkg;
	// Word layout
	localparam int WORD_BITS = 24;
	localparam int DATA_BITS = 16;
	localparam int MODE_BITS = 2;
	localparam int MODE_HI_POS = 17;
	localparam int MODE_LO_POS = 16;
	localparam int CNT_BITS = 5;
	localparam logic [4:0] LAST_EDGE = 5'h18;
	// Values after reset
	localparam logic [15:0] ZERO_SCALE = 16'h0000;
	localparam logic [15:0] MID_SCALE = 16'h8000;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [23:0] SHIFT_RESET = 24'h00_0000;
	// Synchroniser depth
	localparam int SYNC_STAGES = 2;
endpackage : dsw_pkg

// [logic/dsw_sync2.sv]
// Two flip-flop synchroniser for one external level
module dsw_sync2
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Asynchronous level in, synchronised level out
	input wire logic async_in,
	input wire logic rst_val_in,
	output logic sync_out
);
	// All state in one struct
	typedef struct packed
	{
		logic meta;
		logic stable;
	} dsw_sync_t;

	dsw_sync_t st_ff;
	dsw_sync_t nxt_st;

	// First stage feeds only the second
	always_comb
	begin
		nxt_st.meta = async_in;
		nxt_st.stable = st_ff.meta;
	end

	// Synchronous reset loads the idle level
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			// Both stages start at the pin's idle level, so no
			// false edge shows while the stages refill after reset
			st_ff.meta <= rst_val_in;
			st_ff.stable <= rst_val_in;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Output straight from the second stage
	assign sync_out = st_ff.stable;
endmodule // dsw_sync2

// [logic/dsw_write_port.sv]
// Serial write port: frame select, serial clock, data in; holds code and power mode
// Summary of operation
// - Shift register is exactly 24 bits
// - Sample data on serial clock falling edges
// - Only falls while select low shift in
// - After 24th fall, update converter contents
// - Select rising early aborts the frame
// - Word carries two mode bits, 16 data
// - Abort clears shift register, keeps outputs
// - Power-on sets zero or midscale output
module dsw_write_port
#(
	parameter bit RESET_TO_MID = 1'b0
)
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Serial pins from the master
	input wire logic frame_sel_n_in,
	input wire logic ser_clk_in,
	input wire logic ser_data_in,
	// Converter contents
	output logic [15:0] dac_code_out,
	output logic [1:0] power_mode_out,
	output logic update_out
);
	// Whole state of the port
	typedef struct packed
	{
		logic [23:0] shift;
		logic [4:0] count;
		logic sel_n_d;
		logic clk_d;
		logic done;
		logic [15:0] code;
		logic [1:0] mode;
		logic upd;
	} dsw_state_t;

	dsw_state_t st_ff;
	dsw_state_t nxt_st;
	logic sel_n_s; // Synchronised frame select
	logic clk_s; // Synchronised serial clock
	logic data_s; // Synchronised serial data
	logic sel_fall; // Frame starts
	logic sel_rise; // Frame ends or aborts
	logic clk_fall; // Sampling edge
	logic shift_en; // Edge counts in this frame

	// Idle levels: select high, clock high, data low
	// Each pin passes two flip-flops before any logic reads it;
	// reset levels match the idle pins so no edge follows reset
	dsw_sync2 u_sync_sel
	(
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(frame_sel_n_in),
		.rst_val_in(1'b1),
		.sync_out(sel_n_s)
	);
	dsw_sync2 u_sync_clk
	(
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(ser_clk_in),
		.rst_val_in(1'b1),
		.sync_out(clk_s)
	);
	dsw_sync2 u_sync_dat
	(
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(ser_data_in),
		.rst_val_in(1'b0),
		.sync_out(data_s)
	);

	// Edge detection on synchronised levels only
	// Sampling costs up to three reference clocks per edge, so each
	// serial clock half must span at least three of them
	always_comb
	begin
		sel_fall = st_ff.sel_n_d & ~sel_n_s;
		sel_rise = ~st_ff.sel_n_d & sel_n_s;
		clk_fall = st_ff.clk_d & ~clk_s;
		// A clock fall in the same cycle as select falls still counts
		shift_en = clk_fall & ~sel_n_s & ~st_ff.done;
	end

	// Next state
	// Priority: a select rise discards everything, else a counted fall
	// shifts one bit. The done flag blocks falls after the 24th until
	// select rises, so a master may leave select low after a word.
	// Limitation: a fall sampled together with the select rise is lost,
	// because the gate looks at the current select level.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.sel_n_d = sel_n_s;
		nxt_st.clk_d = clk_s;
		nxt_st.upd = 1'b0;
		if (sel_fall)
		begin
			// Fresh frame, count from zero
			nxt_st.count = 5'h00;
			nxt_st.done = 1'b0;
			nxt_st.shift = dsw_pkg::SHIFT_RESET;
		end
		if (sel_rise)
		begin
			// Early rise discards the partial word
			nxt_st.shift = dsw_pkg::SHIFT_RESET;
			nxt_st.count = 5'h00;
			nxt_st.done = 1'b0;
		end
		else if (shift_en)
		begin
			// MSB first into the 24-bit register
			nxt_st.shift = {st_ff.shift[22:0], data_s};
			nxt_st.count = sel_fall ? 5'h01 : st_ff.count + 5'h01;
			if (sel_fall ? 1'b0 : (st_ff.count == dsw_pkg::LAST_EDGE - 5'h01))
			begin
				// Last bit in: apply mode and code together
				nxt_st.code = {st_ff.shift[14:0], data_s};
				nxt_st.mode = st_ff.shift[dsw_pkg::MODE_HI_POS - 1 -: 2];
				nxt_st.upd = 1'b1;
				nxt_st.done = 1'b1;
			end
		end
	end

	// Registers; power-on level of the converter
	// Edge history resets to the idle pin levels, so the first
	// cycles after reset see no select or clock edge
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			st_ff.shift <= dsw_pkg::SHIFT_RESET;
			st_ff.count <= 5'h00;
			st_ff.sel_n_d <= 1'b1;
			st_ff.clk_d <= 1'b1;
			st_ff.done <= 1'b0;
			st_ff.code <= RESET_TO_MID ? dsw_pkg::MID_SCALE : dsw_pkg::ZERO_SCALE;
			st_ff.mode <= dsw_pkg::MODE_NORMAL;
			st_ff.upd <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign dac_code_out = st_ff.code;
	assign power_mode_out = st_ff.mode;
	assign update_out = st_ff.upd;

	// Checks on the state; all are off during reset except the
	// power-on check, which looks at the first cycle after it
	// Outputs change only with an update pulse
	a_code_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!st_ff.upd |-> $stable(st_ff.code) && $stable(st_ff.mode))
		else $error("converter contents changed without update");
	// Update only after exactly 24 counted edges
	a_update_count: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		st_ff.upd |-> st_ff.count == dsw_pkg::LAST_EDGE && st_ff.done)
		else $error("update without 24 edges");
	// Abort leaves shift register cleared
	a_abort_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		sel_rise |=> st_ff.shift == dsw_pkg::SHIFT_RESET && st_ff.count == 5'h00 && !st_ff.upd)
		else $error("abort did not clear the word");
	// No shifting with select high
	a_sel_gate: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		sel_n_s && !sel_rise |=> $stable(st_ff.count))
		else $error("count moved with select high");
	// Count never passes 24
	a_count_max: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		st_ff.count <= dsw_pkg::LAST_EDGE)
		else $error("bit count beyond word length");
	// New frame restarts the count
	a_frame_start: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		sel_fall && !clk_fall |=> st_ff.count == 5'h00)
		else $error("count not restarted");
	// Each counted fall shifts the sampled bit in
	a_shift_bit: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		shift_en && !sel_rise |=> st_ff.shift[0] == $past(data_s))
		else $error("sampled bit not shifted in");
	// Update pulse lasts one cycle
	a_upd_pulse: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		st_ff.upd |=> !st_ff.upd)
		else $error("update longer than one cycle");
	// Power-on level right after reset
	a_reset_level: assert property (@(posedge ref_clk_in)
		$fell(sys_rst_in) |-> st_ff.code == (RESET_TO_MID ? dsw_pkg::MID_SCALE : dsw_pkg::ZERO_SCALE)
			&& st_ff.mode == dsw_pkg::MODE_NORMAL)
		else $error("converter not at power-on level after reset");
	// Abort changes neither code nor mode
	a_abort_keep: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		sel_rise |=> $stable(st_ff.code) && $stable(st_ff.mode))
		else $error("abort changed converter contents");
	// Applied fields match the received word
	a_word_fields: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		st_ff.upd |-> st_ff.code == st_ff.shift[15:0] && st_ff.mode == st_ff.shift[17:16])
		else $error("applied fields differ from the word");
	// Falls after the 24th leave the word alone
	a_late_ignore: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		st_ff.done && !sel_rise |=> $stable(st_ff.shift) && $stable(st_ff.count))
		else $error("fall after word end was counted");
	// Word end comes only with an update
	a_done_upd: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		$rose(st_ff.done) |-> st_ff.upd)
		else $error("word ended without update");
	// Select rise re-arms the port for a new frame
	a_done_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		sel_rise |=> !st_ff.done)
		else $error("select rise did not re-arm the port");
	// Each counted fall adds exactly one to the count
	a_count_step: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		shift_en && !sel_rise && !sel_fall |=> st_ff.count == $past(st_ff.count) + 5'h01)
		else $error("bit count did not step by one");
endmodule // dsw_write_port

// [tb/dsw_master_model.sv]
// Serial master model: frame select, serial clock and data
module dsw_master_model
(
	// Timing reference
	input wire logic ref_clk_in,
	// Serial pins toward the port
	output logic frame_sel_n_out,
	output logic ser_clk_out,
	output logic ser_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle: select high, clock parked high
	initial
	begin
		frame_sel_n_out = 1'b1;
		ser_clk_out = 1'b1;
		ser_data_out = 1'b0;
	end
	// Half of a 160 ns serial period, well under 30 MHz
	task automatic half();
		repeat (4) @(negedge ref_clk_in);
	endtask
	// Send nbits of a word MSB first, then release select
	task automatic send(input logic [23:0] w, input int nbits);
		frame_sel_n_out = 1'b0;
		half();
		for (int i = 23; i > 23 - nbits; i--)
		begin
			ser_data_out = (i >= 0) ? w[i] : 1'b1;
			half();
			ser_clk_out = 1'b0;
			half();
			ser_clk_out = 1'b1;
		end
		half();
		frame_sel_n_out = 1'b1;
		ser_data_out = ~ser_data_out;
		half();
	endtask
	// Clock pulses with select high, only when a test asks
	task automatic stray();
		for (int i = 0; i < 24; i++)
		begin
			ser_data_out = ~ser_data_out;
			half();
			ser_clk_out = ~ser_clk_out;
		end
	endtask
endmodule // dsw_master_model

// [tb/tb.sv]
// Testbench for the serial write port
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic frame_sel_n;
	logic ser_clk;
	logic ser_data;
	logic [15:0] dac_code;
	logic [1:0] power_mode;
	logic update;
	int mismatches;
	int total_checks;
	int upd_cnt;
	// 50 MHz clock
	initial
	begin
		forever #10 ref_clk_in = ~ref_clk_in;
	end
	dsw_master_model mst_u (.ref_clk_in(ref_clk_in), .frame_sel_n_out(frame_sel_n), .ser_clk_out(ser_clk),
		.ser_data_out(ser_data));
	dsw_write_port dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .frame_sel_n_in(frame_sel_n),
		.ser_clk_in(ser_clk), .ser_data_in(ser_data), .dac_code_out(dac_code), .power_mode_out(power_mode),
		.update_out(update));
	// Count update pulses mid-cycle, where they are settled
	always @(negedge ref_clk_in)
		if (update === 1'b1)
			upd_cnt++;
	// Compare and report
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Outputs after reset
	task automatic t_reset();
		chk("code", dsw_pkg::ZERO_SCALE, dac_code);
		chk("mode", 16'(dsw_pkg::MODE_NORMAL), 16'(power_mode));
	endtask
	// Full words in every power mode
	task automatic t_words();
		logic [23:0] w;
		for (int m = 0; m < 4; m++)
		begin
			w = {6'h2A, 2'(m), 16'hA5C3 ^ 16'(m)};
			mst_u.send(w, 24);
			chk("code", w[15:0], dac_code);
			chk("mode", 16'(w[17:16]), 16'(power_mode));
			chk("updates", 16'(m + 1), 16'(upd_cnt));
		end
	endtask
	// Stray clocks, an aborted frame, a clean frame, then one with two extra clocks
	task automatic t_abort();
		mst_u.stray();
		mst_u.send(24'h01_FFFF, 23);
		chk("code", 16'hA5C0, dac_code);
		chk("mode", 16'h0003, 16'(power_mode));
		chk("updates", 16'h0004, 16'(upd_cnt));
		mst_u.send(24'h00_1357, 24);
		chk("code", 16'h1357, dac_code);
		chk("mode", 16'h0000, 16'(power_mode));
		chk("updates", 16'h0005, 16'(upd_cnt));
		mst_u.send(24'h02_4321, 26);
		chk("code", 16'h4321, dac_code);
		chk("mode", 16'h0002, 16'(power_mode));
		chk("updates", 16'h0006, 16'(upd_cnt));
	endtask
	// Verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog, several times the expected run
	initial
	begin
		#100us;
		mismatches++;
		results();
	end
	// Main sequence
	initial
	begin
		repeat (4) @(negedge ref_clk_in);
		sys_rst_in = 1'b0;
		t_reset();
		t_words();
		t_abort();
		results();
	end
endmodule // tb
